// File: rtl/pin_change_defs.vh
// Register offsets, field layout and reset values of the pin change block.
// Assumes a Wishbone slave with 32-bit words at aligned byte addresses.
`ifndef PIN_CHANGE_DEFS_VH
`define PIN_CHANGE_DEFS_VH
`define PC_ADDR_W 5
`define PC_OFS_RISE 5'h00
`define PC_OFS_FALL 5'h04
`define PC_OFS_FLAG 5'h08
`define PC_OFS_CLR 5'h0C
`define PC_OFS_IEN 5'h10
`define PC_PIN_W 6
`define PC_SUM_BIT 6
`define PC_STAT_W 7
`define PC_RST_EN 6'h00
`define PC_RST_STAT 7'h00
`define PC_RST_WORD 32'h0000_0000
`endif

// File: rtl/edge_detector.v
// Per-pin two-stage synchroniser and edge detector.
// Assumes pins may change at any time relative to mclk.
`include "pin_change_defs.vh"
module edge_detector #(
    parameter WIDTH = `PC_PIN_W
) (
    input wire mclk,
    input wire rst,
    input wire [WIDTH-1:0] pinIn,
    output wire [WIDTH-1:0] riseSeen,
    output wire [WIDTH-1:0] fallSeen
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;
    reg [WIDTH-1:0] prev_ff;

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
            prev_ff <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_ff <= pinIn;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // One transition gives one pulse of one cycle
    assign riseSeen = sync_ff & ~prev_ff;
    assign fallSeen = ~sync_ff & prev_ff;
endmodule

// File: rtl/pin_change_edge.v
// Top of the pin change block: Wishbone registers, flags, interrupt.
// Assumes a classic Wishbone master on mclk and asynchronous port pins.
//
// How it works
// - An enabled rising enable bit makes a low-to-high pin edge count.
// - An enabled falling enable bit makes a high-to-low pin edge count.
// - A counted edge sets the pin's change flag and the summary flag.
// - A cleared enable bit ignores that edge direction on that pin.
// - Bits 7 to 6 of both enable registers ignore writes, read zero.
// - Enable bits are read-write and clear to zero on every reset.
//
// The address map and the Wishbone register port were left to the implementer.
`include "pin_change_defs.vh"
module pin_change_edge #(
    parameter PINS = `PC_PIN_W
) (
    input wire mclk,
    input wire rst,
    input wire [PINS-1:0] firstIoPort,
    input wire wbCyc,
    input wire wbStb,
    input wire wbWe,
    input wire [`PC_ADDR_W-1:0] wbAdr,
    input wire [3:0] wbSel,
    input wire [31:0] wbDatI,
    output reg [31:0] wbDatO,
    output reg wbAck,
    output reg changeIrq
);
    reg [PINS-1:0] risingEdgeEnable_ff;
    reg [PINS-1:0] fallingEdgeEnable_ff;
    reg [PINS:0] status_ff;
    reg [PINS:0] irqEnable_ff;
    reg [PINS-1:0] nxt_risingEdgeEnable;
    reg [PINS-1:0] nxt_fallingEdgeEnable;
    reg [PINS:0] nxt_status;
    reg [PINS:0] nxt_irqEnable;
    reg [31:0] nxt_wbDatO;
    reg [PINS:0] clrMask;
    reg [PINS-1:0] hit;
    wire [PINS-1:0] riseSeen;
    wire [PINS-1:0] fallSeen;
    wire req;
    wire wrLow;

    edge_detector #(
        .WIDTH(PINS)
    ) u_edge (
        .mclk(mclk),
        .rst(rst),
        .pinIn(firstIoPort),
        .riseSeen(riseSeen),
        .fallSeen(fallSeen)
    );

    // Single-cycle ack; the low lane carries every field
    assign req = wbCyc & wbStb & ~wbAck;
    assign wrLow = req & wbWe & wbSel[0];

    function [31:0] padWord;
        input [PINS:0] val;
        begin
            padWord = `PC_RST_WORD;
            padWord[PINS:0] = val;
        end
    endfunction

    always @*
    begin
        nxt_risingEdgeEnable = risingEdgeEnable_ff;
        nxt_fallingEdgeEnable = fallingEdgeEnable_ff;
        nxt_irqEnable = irqEnable_ff;
        nxt_wbDatO = `PC_RST_WORD;
        clrMask = {(PINS+1){1'b0}};
        // Masked edges never reach the flags
        hit = (riseSeen & risingEdgeEnable_ff)
            | (fallSeen & fallingEdgeEnable_ff);
        if (wrLow)
        begin
            case (wbAdr)
                // Upper bits are dropped here, never stored
                `PC_OFS_RISE: nxt_risingEdgeEnable = wbDatI[PINS-1:0];
                `PC_OFS_FALL: nxt_fallingEdgeEnable = wbDatI[PINS-1:0];
                `PC_OFS_CLR: clrMask = wbDatI[PINS:0];
                `PC_OFS_IEN: nxt_irqEnable = wbDatI[PINS:0];
                default: clrMask = {(PINS+1){1'b0}};
            endcase
        end
        if (req & ~wbWe)
        begin
            case (wbAdr)
                // Bits 7 to 6 of the enable registers read zero
                `PC_OFS_RISE:
                    nxt_wbDatO = padWord({1'b0, risingEdgeEnable_ff});
                `PC_OFS_FALL:
                    nxt_wbDatO = padWord({1'b0, fallingEdgeEnable_ff});
                `PC_OFS_FLAG: nxt_wbDatO = padWord(status_ff);
                `PC_OFS_IEN: nxt_wbDatO = padWord(irqEnable_ff);
                default: nxt_wbDatO = `PC_RST_WORD;
            endcase
        end
        // Set beats clear in the same cycle
        nxt_status = (status_ff & ~clrMask) | {|hit, hit};
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            // Every reset source lands here
            risingEdgeEnable_ff <= `PC_RST_EN;
            fallingEdgeEnable_ff <= `PC_RST_EN;
            status_ff <= `PC_RST_STAT;
            irqEnable_ff <= `PC_RST_STAT;
            wbDatO <= `PC_RST_WORD;
            wbAck <= 1'b0;
            changeIrq <= 1'b0;
        end
        else
        begin
            risingEdgeEnable_ff <= nxt_risingEdgeEnable;
            fallingEdgeEnable_ff <= nxt_fallingEdgeEnable;
            status_ff <= nxt_status;
            irqEnable_ff <= nxt_irqEnable;
            wbDatO <= nxt_wbDatO;
            wbAck <= req;
            // Built from next values, so it rises with the flag
            changeIrq <= |(nxt_status & nxt_irqEnable);
        end
    end
endmodule

// File: testbench/pin_change_edge_properties.sv
// Checker of the pin change block's bus and interrupt ports.
// Assumes a classic Wishbone master holding requests until ack.
module pin_change_props #(parameter PINS = 6) (
    input wire mclk,
    input wire rst,
    input wire [PINS-1:0] firstIoPort,
    input wire wbCyc,
    input wire wbStb,
    input wire wbWe,
    input wire [4:0] wbAdr,
    input wire [3:0] wbSel,
    input wire [31:0] wbDatI,
    input wire [31:0] wbDatO,
    input wire wbAck,
    input wire changeIrq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] riseEn_ff, fallEn_ff;
    wire wr = wbAck && wbWe && wbSel[0];
    // Shadow taken at the ack edge, later than the design's own update
    always_ff @(posedge mclk or posedge rst)
        if (rst) {riseEn_ff, fallEn_ff} <= 12'h000;
        else if (wr && wbAdr == 5'h00) riseEn_ff <= wbDatI[5:0];
        else if (wr && wbAdr == 5'h04) fallEn_ff <= wbDatI[5:0];
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ack_pulse_a: assert property (wbAck |=> !wbAck)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
        else $error("ack late");
    idle_data_a: assert property (!wbAck |-> wbDatO == 32'h0000_0000)
        else $error("read data outside ack");
    rise_read_a: assert property (
        wbAck && !wbWe && wbAdr == 5'h00 |-> wbDatO[5:0] == riseEn_ff)
        else $error("rising enable readback");
    fall_read_a: assert property (
        wbAck && !wbWe && wbAdr == 5'h04 |-> wbDatO[5:0] == fallEn_ff)
        else $error("falling enable readback");
    upper_zero_a: assert property (
        wbAck && !wbWe && wbAdr < 5'h08 |-> wbDatO[31:6] == 26'h000_0000)
        else $error("upper enable bits not zero");
    irq_sticky_a: assert property (
        changeIrq && !wbCyc && !$past(wbCyc) |=> changeIrq)
        else $error("interrupt dropped without clear");
endmodule
bind pin_change_edge pin_change_props #(.PINS(PINS)) props (.mclk, .rst,
    .firstIoPort, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI, .wbDatO,
    .wbAck, .changeIrq);

// File: testbench/pin_change_edge_tb.sv
// Self-checking bench of the pin change block.
// Assumes the block answers every Wishbone request with ack.
module pin_change_edge_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, changeIrq;
    logic [5:0] pins = 6'h00;
    logic [4:0] wbAdr = 5'h00;
    logic [3:0] wbSel = 4'h1;
    logic [31:0] wbDatI = 32'h0000_0000, wbDatO, rd;
    int failCount = 0, checkCount = 0, cyc = 0;
    pin_change_edge dut (.mclk, .rst, .firstIoPort(pins), .wbCyc, .wbStb,
        .wbWe, .wbAdr, .wbSel, .wbDatI, .wbDatO, .wbAck, .changeIrq);
    always #5 mclk = ~mclk;
    task give_verdict;
        $display("Checks %0d, mismatches %0d", checkCount, failCount);
        if (failCount == 0 && checkCount > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge mclk)
        if (++cyc == 2000)
        begin
            failCount++;
            give_verdict();
        end
    task chk(input logic [31:0] s, e);
        checkCount++;
        if (s !== e)
        begin
            failCount++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask
    // Held until ack is sampled high; only then released
    task bus(input logic we, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, we, a, d};
        do @(posedge mclk); while (wbAck !== 1'b1);
        rd = wbDatO;
        {wbCyc, wbStb} <= 2'b00;
        @(posedge mclk);
    endtask
    task rdc(input logic [4:0] a, input logic [31:0] e);
        bus(0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    // Six cycles cover synchroniser, flag and interrupt stages
    task pin(input logic [5:0] v);
        @(posedge mclk) pins <= v;
        repeat (6) @(posedge mclk);
    endtask
    task resetVals;
        rdc(5'h00, 32'h0000_0000);
        rdc(5'h04, 32'h0000_0000);
    endtask
    task widthCheck;
        bus(1, 5'h00, 32'h0000_00FF);
        rdc(5'h00, 32'h0000_003F);
        bus(1, 5'h04, 32'h0000_00FF);
        rdc(5'h04, 32'h0000_003F);
    endtask
    task edges;
        bus(1, 5'h10, 32'h0000_007F);
        bus(1, 5'h00, 32'h0000_0001);
        bus(1, 5'h04, 32'h0000_0002);
        pin(6'h02);
        rdc(5'h08, 32'h0000_0000);
        pin(6'h03);
        rdc(5'h08, 32'h0000_0041);
        chk(changeIrq, 32'h0000_0001);
        bus(1, 5'h0C, 32'h0000_007F);
        rdc(5'h08, 32'h0000_0000);
        chk(changeIrq, 32'h0000_0000);
        pin(6'h01);
        rdc(5'h08, 32'h0000_0042);
        bus(1, 5'h0C, 32'h0000_007F);
        pin(6'h00);
        rdc(5'h08, 32'h0000_0000);
        bus(1, 5'h10, 32'h0000_0000);
        pin(6'h01);
        rdc(5'h08, 32'h0000_0041);
        chk(changeIrq, 32'h0000_0000);
        bus(1, 5'h0C, 32'h0000_0001);
        rdc(5'h08, 32'h0000_0040);
        bus(1, 5'h0C, 32'h0000_0040);
        rdc(5'h08, 32'h0000_0000);
    endtask
    // Reset in mid-run must wipe what software wrote
    task midReset;
        bus(1, 5'h04, 32'h0000_0015);
        rdc(5'h04, 32'h0000_0015);
        @(posedge mclk) rst <= 1;
        repeat (2) @(posedge mclk);
        rst <= 0;
        resetVals();
    endtask
    initial
    begin
        repeat (3) @(posedge mclk);
        rst <= 0;
        resetVals();
        widthCheck();
        midReset();
        edges();
        give_verdict();
    end
endmodule
